// ### include/ivfl_pkg.sv
// Constants and carrier types of the input voltage fault limit block
package ivfl_pkg;

   ///////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CODE_OV_ACTION    = 8'h56;
   localparam logic [7:0] CODE_OV_WARN      = 8'h57;
   localparam logic [7:0] CODE_UV_WARN      = 8'h58;
   localparam logic [7:0] CODE_UV_FAULT     = 8'h59;
   localparam logic [7:0] CODE_STATUS_WORD  = 8'h79;
   localparam logic [7:0] CODE_STATUS_INPUT = 8'h7c;

   ///////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]  OV_ACTION_RST = 8'h80;
   localparam logic [15:0] OV_WARN_RST   = 16'hd360;

   ///////////////////////////////////////////////////////////////////////////
   // Fault action fields and encodings
   localparam int          RESP_MSB   = 7;
   localparam int          RESP_LSB   = 6;
   localparam int          RETRY_MSB  = 5;
   localparam int          RETRY_LSB  = 3;
   localparam int          DELAY_MSB  = 2;
   localparam int          DELAY_LSB  = 0;
   localparam logic [1:0]  RESP_HOLD  = 2'h3;
   localparam logic [2:0]  RETRY_CONT = 3'h7;

   ///////////////////////////////////////////////////////////////////////////
   // Linear-11 layout and internal voltage scale
   localparam int EXP_MSB       = 15;
   localparam int EXP_LSB       = 11;
   localparam int MANT_MSB      = 10;
   localparam int MANT_LSB      = 0;
   localparam int VIN_FRAC_BITS = 8;
   localparam int UV_WARN_NUM   = 11;
   localparam int UV_WARN_DEN   = 10;

   ///////////////////////////////////////////////////////////////////////////
   // Status bit positions
   localparam int SI_OV_FAULT = 7;
   localparam int SI_OV_WARN  = 6;
   localparam int SI_UV_WARN  = 5;
   localparam int SI_UV_FAULT = 4;
   localparam int SW_INPUT    = 13;
   localparam int SW_NOTA     = 0;

   ///////////////////////////////////////////////////////////////////////////
   // Threshold slots
   localparam int THR_OV_WARN  = 0;
   localparam int THR_UV_WARN  = 1;
   localparam int THR_UV_FAULT = 2;
   localparam int THR_NUM      = 3;

   ///////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int RETRY_UNIT_MS  = 35;
   localparam int CLK_HZ         = 125_000_000;
   localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * (CLK_HZ / 1000);

   ///////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } ivfl_cmd_s;

   typedef struct packed {
      logic        ack;
      logic        refused;
      logic [15:0] data;
   } ivfl_rsp_s;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_OFF,
      ST_LATCH,
      ST_HOLD,
      ST_WAIT
   } ivfl_state_e;

endpackage : ivfl_pkg

// ### verilog/ivfl_lin11_q8.sv
// Linear-11 threshold to unsigned fixed-point volts converter
`timescale 1ns/10ps
`default_nettype none
module ivfl_lin11_q8
   import ivfl_pkg::*;
(
   // Linear-11 word in
   input  wire logic [15:0] lin,
   // Volts with VIN_FRAC_BITS fraction bits, saturated, negative as zero
   output var  logic [15:0] q8
);

   logic signed [6:0] sh;
   logic        [31:0] mag;

   always_comb begin
      sh  = 7'(signed'(lin[EXP_MSB:EXP_LSB])) + 7'(VIN_FRAC_BITS);
      mag = 32'h0;
      q8  = 16'h0;
      if (lin[MANT_MSB] || lin[MANT_MSB-1:MANT_LSB] == 10'h0) begin
         q8 = 16'h0;
      end else if (sh >= 7'sd0) begin
         if (sh > 7'sd16) begin
            q8 = 16'hffff;
         end else begin
            mag = 32'(lin[MANT_MSB-1:MANT_LSB]) << sh[4:0];
            q8  = (mag[31:16] != 16'h0) ? 16'hffff : mag[15:0];
         end
      end else begin
         mag = 32'(lin[MANT_MSB-1:MANT_LSB]) >> 5'(-sh);
         q8  = mag[15:0];
      end
   end

endmodule : ivfl_lin11_q8
`default_nettype wire

// ### verilog/ivfl_limits.sv
// Input voltage fault limits, status and overvoltage fault action
`timescale 1ns/10ps
`default_nettype none
module ivfl_limits
   import ivfl_pkg::*;
#(
   parameter int RetryUnitCyc = RETRY_UNIT_CYC
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Command port
   input  wire ivfl_cmd_s   cmd,
   input  wire logic        writeProtect,
   output var  ivfl_rsp_s   rsp,
   // Monitoring
   input  wire logic        sampleValid,
   input  wire logic [15:0] sampleVin,
   input  wire logic        ovFaultDet,
   input  wire logic [15:0] uvloStrap,
   // Power control
   input  wire logic        enableOn,
   input  wire logic        biasOk,
   input  wire logic        otherFault,
   input  wire logic        restartReq,
   output logic             outputEn,
   output logic             uvFaultActive,
   // Alert and status
   output logic             alertLine_b,
   output logic [7:0]       statusInput
);

   ///////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      ivfl_state_e             st;
      logic [7:0]              ovAction;
      logic [THR_NUM-1:0][15:0] thr;
      logic [7:0]              stIn;
      logic                    ovWarnC;
      logic                    uvWarnC;
      logic                    uvFaultC;
      logic                    uvFaultAct;
      logic                    ovFaultPrev;
      logic                    strapDone;
      logic                    outEn;
      logic                    alert_b;
      logic [31:0]             cnt;
      ivfl_rsp_s               rsp;
   } ivfl_regs_s;

   ivfl_regs_s s_q;
   ivfl_regs_s s_d;
   logic       rstMeta_q;
   logic       rstSync_q;

   logic [THR_NUM-1:0][15:0] thrV;

   ///////////////////////////////////////////////////////////////////////////
   // Reset release

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Threshold decode into volts

   genvar gi;
   generate
      for (gi = 0; gi < THR_NUM; gi++) begin : gThr
         ivfl_lin11_q8 uConv (
            .lin (s_q.thr[gi]),
            .q8  (thrV[gi])
         );
      end
   endgenerate

   ///////////////////////////////////////////////////////////////////////////
   // Under-voltage warn default from strap, mantissa times 1.10

   function automatic logic [15:0] scaleUv(input logic [15:0] lin);
      logic signed [15:0] m;
      logic signed [15:0] p;
      logic        [4:0]  e;
      m = 16'(signed'(lin[MANT_MSB:MANT_LSB]));
      p = 16'((32'(m) * UV_WARN_NUM) / UV_WARN_DEN);
      e = lin[EXP_MSB:EXP_LSB];
      // Renormalise when the scaled mantissa leaves eleven bits
      if (p > 16'sd1023 || p < -16'sd1024) begin
         p = p >>> 1;
         e = e + 5'h1;
      end
      return {e, p[MANT_MSB:MANT_LSB]};
   endfunction : scaleUv

   ///////////////////////////////////////////////////////////////////////////
   // Next state

   logic [1:0]  respCode;
   logic [2:0]  retryCode;
   logic [2:0]  delayCode;
   logic        ovFaultRise;
   logic        runAllowed;
   logic        wrOk;
   logic        clrFaults;
   logic [7:0]  setIn;
   logic [31:0] retryCyc;

   always_comb begin
      s_d         = s_q;
      respCode    = s_q.ovAction[RESP_MSB:RESP_LSB];
      retryCode   = s_q.ovAction[RETRY_MSB:RETRY_LSB];
      delayCode   = s_q.ovAction[DELAY_MSB:DELAY_LSB];
      ovFaultRise = ovFaultDet && !s_q.ovFaultPrev;
      runAllowed  = enableOn && biasOk && !otherFault;
      wrOk        = cmd.valid && cmd.write && !writeProtect;
      clrFaults   = cmd.valid && cmd.write
                    && cmd.code == CODE_CLEAR_FAULTS;
      setIn       = 8'h0;
      retryCyc    = 32'((32'(delayCode) + 32'h1) * 32'(RetryUnitCyc));

      s_d.ovFaultPrev = ovFaultDet;

      // Strapped lockout level loaded once after reset release
      if (!s_q.strapDone) begin
         s_d.strapDone         = 1'b1;
         s_d.thr[THR_UV_FAULT] = uvloStrap;
         s_d.thr[THR_UV_WARN]  = scaleUv(uvloStrap);
      end

      // Comparisons on each sample, edges raise status once
      if (sampleValid) begin
         s_d.ovWarnC  = sampleVin > thrV[THR_OV_WARN];
         s_d.uvWarnC  = sampleVin < thrV[THR_UV_WARN];
         s_d.uvFaultC = sampleVin < thrV[THR_UV_FAULT];
         if (s_d.uvFaultC) begin
            s_d.uvFaultAct = 1'b1;
         end else if (sampleVin > thrV[THR_UV_WARN]) begin
            s_d.uvFaultAct = 1'b0;
         end
      end
      setIn[SI_OV_WARN]  = s_d.ovWarnC && !s_q.ovWarnC;
      setIn[SI_UV_WARN]  = s_d.uvWarnC && !s_q.uvWarnC;
      setIn[SI_UV_FAULT] = s_d.uvFaultAct && !s_q.uvFaultAct;
      setIn[SI_OV_FAULT] = ovFaultRise;

      // Sticky status, a new event wins over clear-faults
      if (clrFaults) begin
         s_d.stIn = 8'h0;
      end
      s_d.stIn    = s_d.stIn | setIn;
      s_d.alert_b = (s_d.stIn == 8'h0);

      // Overvoltage fault action sequencer
      if (s_q.cnt != 32'h0) begin
         s_d.cnt = s_q.cnt - 32'h1;
      end
      unique case (s_q.st)
         ST_RUN: begin
            if (ovFaultRise) begin
               if (respCode == RESP_HOLD) begin
                  s_d.st = ST_HOLD;
               end else if (retryCode == RETRY_CONT) begin
                  s_d.st  = ST_WAIT;
                  s_d.cnt = retryCyc - 32'h1;
               end else begin
                  s_d.st = ST_LATCH;
               end
            end else if (!runAllowed) begin
               s_d.st = ST_OFF;
            end
         end
         ST_OFF: begin
            if (runAllowed && !ovFaultDet) begin
               s_d.st = ST_RUN;
            end
         end
         ST_LATCH: begin
            if (restartReq) begin
               s_d.st = runAllowed ? ST_RUN : ST_OFF;
            end
         end
         ST_HOLD: begin
            if (!ovFaultDet && !s_q.ovWarnC) begin
               s_d.st = runAllowed ? ST_RUN : ST_OFF;
            end
         end
         ST_WAIT: begin
            if (!runAllowed) begin
               s_d.st  = ST_OFF;
               s_d.cnt = 32'h0;
            end else if (s_q.cnt == 32'h0) begin
               // Retry attempt; a fault still present trips again
               if (ovFaultDet) begin
                  s_d.cnt = retryCyc - 32'h1;
               end else begin
                  s_d.st = ST_RUN;
               end
            end
         end
         default: begin
            s_d.st = ST_OFF;
         end
      endcase
      s_d.outEn = (s_d.st == ST_RUN) && runAllowed && !ovFaultDet;

      // Command port, answered on the cycle after the request
      s_d.rsp = '0;
      if (cmd.valid) begin
         s_d.rsp.ack = 1'b1;
         unique case (cmd.code)
            CODE_CLEAR_FAULTS: begin
               s_d.rsp.refused = !cmd.write;
            end
            CODE_OV_ACTION: begin
               if (wrOk) begin
                  s_d.ovAction = cmd.data[7:0];
               end
               s_d.rsp.refused = cmd.write && writeProtect;
               s_d.rsp.data    = {8'h0, s_q.ovAction};
            end
            CODE_OV_WARN, CODE_UV_WARN, CODE_UV_FAULT: begin
               if (wrOk) begin
                  s_d.thr[cmd.code - CODE_OV_WARN] = cmd.data;
               end
               s_d.rsp.refused = cmd.write && writeProtect;
               s_d.rsp.data    = s_q.thr[cmd.code - CODE_OV_WARN];
            end
            CODE_STATUS_WORD: begin
               s_d.rsp.refused           = cmd.write;
               s_d.rsp.data[SW_INPUT]    = |s_q.stIn;
               s_d.rsp.data[SW_NOTA]     = |s_q.stIn;
            end
            CODE_STATUS_INPUT: begin
               s_d.rsp.refused = cmd.write;
               s_d.rsp.data    = {8'h0, s_q.stIn};
            end
            default: begin
               s_d.rsp.refused = 1'b1;
            end
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         s_q                   <= '0;
         s_q.st                <= ST_OFF;
         s_q.ovAction          <= OV_ACTION_RST;
         s_q.thr[THR_OV_WARN]  <= OV_WARN_RST;
         s_q.alert_b           <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rsp           = s_q.rsp;
   assign outputEn      = s_q.outEn;
   assign uvFaultActive = s_q.uvFaultAct;
   assign alertLine_b   = s_q.alert_b;
   assign statusInput   = s_q.stIn;

endmodule : ivfl_limits
`default_nettype wire

// ### verif/ivfl_host_model.sv
// Host model that issues single requests on the command port
`timescale 1ns/10ps
`default_nettype none
module ivfl_host_model
   import ivfl_pkg::*;
(
   // Clock
   input  wire logic      clk,
   // Command port
   input  wire ivfl_rsp_s rsp,
   output var  ivfl_cmd_s cmd
);
   initial cmd = '0;

   // Answer is taken the cycle after; idle lines carry scrambled values
   task automatic xfer(input logic w, input logic [7:0] c,
         input logic [15:0] d, output ivfl_rsp_s r);
      @(negedge clk);
      cmd = '{valid: 1'b1, write: w, code: c, data: d};
      @(negedge clk);
      r = rsp;
      cmd = '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
   endtask : xfer
endmodule : ivfl_host_model
`default_nettype wire

// ### verif/ivfl_limits_sva.sv
// Port checks of the input voltage fault limit block
`timescale 1ns/10ps
`default_nettype none
module ivfl_limits_sva
   import ivfl_pkg::*;
#(
   parameter int RetryUnitCyc = RETRY_UNIT_CYC
)(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // Command port
   input wire ivfl_cmd_s   cmd,
   input wire logic        writeProtect,
   input wire ivfl_rsp_s   rsp,
   // Monitoring
   input wire logic        sampleValid,
   input wire logic [15:0] sampleVin,
   input wire logic        ovFaultDet,
   input wire logic [15:0] uvloStrap,
   // Power control
   input wire logic        enableOn,
   input wire logic        biasOk,
   input wire logic        otherFault,
   input wire logic        restartReq,
   input wire logic        outputEn,
   input wire logic        uvFaultActive,
   // Alert and status
   input wire logic        alertLine_b,
   input wire logic [7:0]  statusInput
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic clearReq;
   assign clearReq = cmd.valid && cmd.write && cmd.code == CODE_CLEAR_FAULTS;

   ack_next_a:
      assert property (cmd.valid |=> rsp.ack) else $error("no answer");
   ack_cause_a:
      assert property (rsp.ack |-> $past(cmd.valid)) else $error("stray ack");
   refuse_protect_a:
      assert property (cmd.valid && cmd.write && writeProtect && cmd.code
         inside {[CODE_OV_ACTION:CODE_UV_FAULT]} |=> rsp.refused)
      else $error("protected write taken");
   refuse_ack_a:
      assert property (rsp.refused |-> rsp.ack) else $error("lone refusal");
   alert_low_a:
      assert property (alertLine_b == (statusInput == 8'h0))
      else $error("alert disagrees with status");
   sticky_bits_a:
      assert property (!clearReq |=>
         (statusInput & $past(statusInput)) == $past(statusInput))
      else $error("status bit lost");
   ov_shutdown_a:
      assert property (ovFaultDet && outputEn |=>
         !outputEn && statusInput[SI_OV_FAULT] && !alertLine_b)
      else $error("fault not acted on");
   on_allowed_a:
      assert property ($rose(outputEn) |->
         $past(enableOn && biasOk && !otherFault))
      else $error("output on while not allowed");
   off_disable_a:
      assert property (!enableOn |-> ##[1:2] !outputEn)
      else $error("output on while disabled");
   uv_sample_a:
      assert property ($changed(uvFaultActive) |-> $past(sampleValid))
      else $error("fault moved without sample");
   warn_sample_a:
      assert property ($rose(statusInput[SI_OV_WARN]) |-> $past(sampleValid))
      else $error("warning without sample");
endmodule : ivfl_limits_sva

bind ivfl_limits ivfl_limits_sva #(.RetryUnitCyc(RetryUnitCyc))
   ivfl_limits_sva_i (.*);
`default_nettype wire

// ### verif/test_input_voltage_fault_limits.sv
// Self-checking bench of the input voltage fault limit block
`timescale 1ns/10ps
`default_nettype none
module test_input_voltage_fault_limits
   import ivfl_pkg::*;
;
   localparam int          Unit  = 20;
   localparam logic [15:0] Strap = 16'he0a0;
   logic        clk = 1'b0;
   logic        rst_b, writeProtect, sampleValid, ovFaultDet, enableOn;
   logic        biasOk, otherFault, restartReq, outputEn, uvFaultActive;
   logic        alertLine_b;
   logic [15:0] sampleVin, uvloStrap;
   logic [7:0]  statusInput, c;
   logic [7:0]  la [5] = '{8'h00, 8'h40, 8'h80, 8'h88, 8'hb0};
   ivfl_cmd_s   cmd;
   ivfl_rsp_s   rsp, r;
   int          failures, check_count, cyc, seed, k, d, n;
   int          mdl [4];

   ivfl_limits #(.RetryUnitCyc(Unit)) ivfl_limits_i (.clk(clk),
      .rst_b(rst_b), .cmd(cmd), .writeProtect(writeProtect), .rsp(rsp),
      .sampleValid(sampleValid), .sampleVin(sampleVin),
      .ovFaultDet(ovFaultDet), .uvloStrap(uvloStrap), .enableOn(enableOn),
      .biasOk(biasOk), .otherFault(otherFault), .restartReq(restartReq),
      .outputEn(outputEn), .uvFaultActive(uvFaultActive),
      .alertLine_b(alertLine_b), .statusInput(statusInput));
   ivfl_host_model ivfl_host_model_i (.clk(clk), .rsp(rsp), .cmd(cmd));

   always #4 clk = ~clk;

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         $display("Error at %0t: timeout", $time);
         failures++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      ivfl_host_model_i.xfer(1'b1, c, d, r);
      chk(16'({r.ack, r.refused}),
         16'({1'b1, writeProtect && c != CODE_CLEAR_FAULTS}));
      if (!writeProtect && c != CODE_CLEAR_FAULTS)
         mdl[c - 8'h56] = (c == CODE_OV_ACTION) ? int'(d[7:0]) : int'(d);
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [15:0] e,
         input logic rf);
      ivfl_host_model_i.xfer(1'b0, c, 16'h0, r);
      chk(16'({r.ack, r.refused}), 16'({1'b1, rf}));
      if (!rf)
         chk(r.data, e);
   endtask : rd

   // Sample in tenths of a volt, handed over as 1/256 V
   task automatic smp(input int t);
      @(negedge clk);
      sampleValid = 1'b1;
      sampleVin = 16'(t * 256 / 10);
      @(negedge clk);
      sampleValid = 1'b0;
      sampleVin = ~sampleVin;
   endtask : smp

   task automatic fault(input int h);
      @(negedge clk);
      ovFaultDet = 1'b1;
      repeat (h) @(negedge clk);
      ovFaultDet = 1'b0;
   endtask : fault

   task automatic wait_on(inout int k, input int lim);
      while (outputEn !== 1'b1 && k < lim) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_on

   function automatic int q8(logic [15:0] w);
      int e;
      int m;
      e = $signed(w[15:11]) + 8;
      m = $signed(w[10:0]);
      return e >= 0 ? m <<< e : m >>> -e;
   endfunction : q8

   initial begin
      rst_b = 1'b0;
      writeProtect = 1'b0;
      sampleValid = 1'b0;
      sampleVin = 16'h0;
      ovFaultDet = 1'b0;
      uvloStrap = Strap;
      enableOn = 1'b1;
      biasOk = 1'b1;
      otherFault = 1'b0;
      restartReq = 1'b0;
      seed = 51680;
      mdl = '{'h80, 'hd360, 0, Strap};
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      rd(CODE_OV_ACTION, OV_ACTION_RST, 1'b0);
      rd(CODE_OV_WARN, OV_WARN_RST, 1'b0);
      rd(CODE_UV_FAULT, Strap, 1'b0);
      ivfl_host_model_i.xfer(1'b0, CODE_UV_WARN, 16'h0, r);
      chk(16'(q8(r.data)), 16'd2816);
      wr(CODE_UV_WARN, 16'he0b0);
      for (n = 0; n < 24; n++) begin
         writeProtect = ($random(seed) & 3) == 0;
         c = 8'h56 + 8'($random(seed) & 3);
         wr(c, 16'($random(seed)));
         rd(c, 16'(mdl[c - 8'h56]), 1'b0);
      end
      writeProtect = 1'b0;
      wr(CODE_OV_ACTION, 16'h80);
      wr(CODE_OV_WARN, OV_WARN_RST);
      wr(CODE_UV_WARN, 16'he0b0);
      wr(CODE_UV_FAULT, Strap);
      rd(8'h5a, 16'h0, 1'b1);
      ivfl_host_model_i.xfer(1'b1, CODE_STATUS_INPUT, 16'hff, r);
      chk(16'({r.ack, r.refused, statusInput}), 16'h300);
      smp(140);
      chk(16'({statusInput, alertLine_b}), 16'h080);
      rd(CODE_STATUS_WORD, 16'h2001, 1'b0);
      wr(CODE_CLEAR_FAULTS, 16'h0);
      smp(140);
      chk(16'({statusInput, alertLine_b}), 16'h001);
      smp(120);
      smp(140);
      chk(16'(statusInput), 16'h40);
      smp(120);
      wr(CODE_CLEAR_FAULTS, 16'h0);
      smp(90);
      chk(16'({statusInput, uvFaultActive}), 16'h61);
      smp(105);
      chk(16'(uvFaultActive), 16'h1);
      smp(115);
      chk(16'(uvFaultActive), 16'h0);
      wr(CODE_CLEAR_FAULTS, 16'h0);
      foreach (la[i]) begin
         wr(CODE_OV_ACTION, 16'(la[i]));
         fault(1);
         chk(16'({outputEn, statusInput[7], alertLine_b}), 16'h2);
         repeat (3 * Unit) @(negedge clk);
         chk(16'(outputEn), 16'h0);
         restartReq = 1'b1;
         @(negedge clk);
         restartReq = 1'b0;
         k = 0;
         wait_on(k, 5);
         chk(16'(outputEn), 16'h1);
         wr(CODE_CLEAR_FAULTS, 16'h0);
      end
      for (d = 0; d < 8; d += 7) begin
         wr(CODE_OV_ACTION, 16'h00b8 | 16'(d));
         k = (d + 1) * Unit + 4;
         fault(k);
         wait_on(k, 400);
         chk(16'(k >= 2 * (d + 1) * Unit && k <= 2 * (d + 1) * Unit + 3),
            16'h1);
      end
      // Disable, bias loss and another fault each end the retrying
      for (n = 0; n < 3; n++) begin
         fault(2);
         {enableOn, biasOk, otherFault} = 3'h6 ^ (3'h4 >> n);
         repeat (3 * Unit) @(negedge clk);
         chk(16'(outputEn), 16'h0);
         {enableOn, biasOk, otherFault} = 3'h6;
         k = 0;
         wait_on(k, 5);
         chk(16'(outputEn), 16'h1);
      end
      wr(CODE_OV_ACTION, 16'hc0);
      smp(140);
      fault(1);
      repeat (3 * Unit) @(negedge clk);
      chk(16'(outputEn), 16'h0);
      smp(120);
      k = 0;
      wait_on(k, 5);
      chk(16'(outputEn), 16'h1);
      wr(CODE_OV_ACTION, 16'h80);
      wrap_up();
   end
endmodule : test_input_voltage_fault_limits
`default_nettype wire
